/* File: logic/cmp1_mode_map.svh */
// Offsets, field positions and reset values of the comparator1 mode register
`ifndef CMP1_MODE_MAP_SVH
`define CMP1_MODE_MAP_SVH

// ==========================================================================
// Register address and reset value
`define CMP1_MODE_SEL_ADDR      8'h9C
`define CMP1_MODE_SEL_RESET     8'h02

// ==========================================================================
// Field positions
`define CMP1_RISE_IRQ_EN_BIT    5
`define CMP1_FALL_IRQ_EN_BIT    4
`define CMP1_RESP_MODE_HI_BIT   1
`define CMP1_RESP_MODE_LO_BIT   0
`define CMP1_MODE_WR_MASK       8'h33

// ==========================================================================
// Typical response times per mode, in ns
`define CMP1_RESP_MODE0_NS      100
`define CMP1_RESP_MODE1_NS      175
`define CMP1_RESP_MODE2_NS      320
`define CMP1_RESP_MODE3_NS      1050

`endif

/* File: logic/cmp1_mode_pkg.sv */
// Types for the comparator1 mode register block
package cmp1_mode_pkg;

	typedef enum logic [1:0] {
		RESP_MODE_FASTEST,
		RESP_MODE_FAST,
		RESP_MODE_SLOW,
		RESP_MODE_SLOWEST
	} resp_mode_t;

	// Register image as seen by software
	typedef struct packed {
		logic [1:0] unused_hi;
		logic       cmp1_rise_irq_en;
		logic       cmp1_fall_irq_en;
		logic [1:0] unused_lo;
		resp_mode_t cmp1_resp_mode;
	} mode_reg_t;

	// Special-function register access from the core
	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} sfr_req_t;

endpackage

/* File: logic/cmp1_mode_regs.sv */
// Comparator1 mode select register with edge-event interrupt request
//
// Operation
// - Bits 7, 6, 3 and 2 of the mode register read as zero and ignore writes.
// - Bit 5 enables a rising-edge event to request an interrupt.
// - Bit 4 enables a falling-edge event to request an interrupt.
// - Bits 1-0 hold the response-time mode code driven to the comparator.
// - A rising comparator output sets a sticky flag cleared only by a software zero write.
// - A falling comparator output sets a sticky flag cleared only by a software zero write.
`timescale 1ns/10ps
`include "cmp1_mode_map.svh"

module cmp1_mode_regs
	import cmp1_mode_pkg::*;
(
	// Clock and reset
	input  wire logic       MCLK_I,
	input  wire logic       RST_N_I,
	// Special-function register access
	input  wire sfr_req_t   SFR_REQ_I,
	output logic      [7:0] SFR_RDATA_O,
	// Comparator output and edge flags from the control register
	input  wire logic       CMP1_OUT_I,
	input  wire logic       FLAG_WR_I,
	input  wire logic       RISE_FLAG_WDATA_I,
	input  wire logic       FALL_FLAG_WDATA_I,
	output logic            CMP1_RISE_FLAG_O,
	output logic            CMP1_FALL_FLAG_O,
	// Analog side and interrupt
	output resp_mode_t      CMP1_RESP_MODE_O,
	output logic            CMP1_IRQ_O
);

	// ======================================================================
	// Mode register
	mode_reg_t mode_reg;
	logic      sel;
	logic      cmp_prev;
	logic      rise_evt;
	logic      fall_evt;

	// ======================================================================
	// Elaboration checks
	// The mask and field positions assume a byte-wide register image
	localparam int REG_W = $bits(mode_reg_t);

	if (REG_W != 8) begin : g_reg_w_bad
		$error("mode register image must be 8 bits wide");
	end

	assign sel = SFR_REQ_I.addr == `CMP1_MODE_SEL_ADDR;

	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			mode_reg <= mode_reg_t'(`CMP1_MODE_SEL_RESET);
		end else if (sel && SFR_REQ_I.wr) begin
			// Unused bits masked off so they stay zero
			mode_reg <= mode_reg_t'(SFR_REQ_I.wdata & `CMP1_MODE_WR_MASK);
		end
	end

	assign CMP1_RESP_MODE_O = mode_reg.cmp1_resp_mode;

	// ======================================================================
	// Read data, registered
	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			SFR_RDATA_O <= 8'h00;
		end else if (sel && SFR_REQ_I.rd) begin
			SFR_RDATA_O <= 8'(mode_reg) & `CMP1_MODE_WR_MASK;
		end else begin
			SFR_RDATA_O <= 8'h00;
		end
	end

	// ======================================================================
	// Edge detection
	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			cmp_prev <= 1'b0;
		end else begin
			cmp_prev <= CMP1_OUT_I;
		end
	end

	assign rise_evt = CMP1_OUT_I & ~cmp_prev;
	assign fall_evt = ~CMP1_OUT_I & cmp_prev;

	// ======================================================================
	// Sticky flags; a new edge wins over a same-cycle clear
	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			CMP1_RISE_FLAG_O <= 1'b0;
		end else if (rise_evt) begin
			CMP1_RISE_FLAG_O <= 1'b1;
		end else if (FLAG_WR_I && !RISE_FLAG_WDATA_I) begin
			CMP1_RISE_FLAG_O <= 1'b0;
		end
	end

	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			CMP1_FALL_FLAG_O <= 1'b0;
		end else if (fall_evt) begin
			CMP1_FALL_FLAG_O <= 1'b1;
		end else if (FLAG_WR_I && !FALL_FLAG_WDATA_I) begin
			CMP1_FALL_FLAG_O <= 1'b0;
		end
	end

	// ======================================================================
	// Interrupt request
	assign CMP1_IRQ_O = (CMP1_RISE_FLAG_O & mode_reg.cmp1_rise_irq_en)
		| (CMP1_FALL_FLAG_O & mode_reg.cmp1_fall_irq_en);

	// ======================================================================
	// Assertions
	a_unused_read_zero: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
		(SFR_RDATA_O[7:6] == 2'b00) && (SFR_RDATA_O[3:2] == 2'b00))
		else $error("unused mode bits read nonzero");

	a_mode_write_lands: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
		sel && SFR_REQ_I.wr |=> CMP1_RESP_MODE_O == resp_mode_t'($past(SFR_REQ_I.wdata[1:0])))
		else $error("response mode not taken from write");

	a_rise_en_write: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
		sel && SFR_REQ_I.wr |=> mode_reg.cmp1_rise_irq_en == $past(SFR_REQ_I.wdata[5]))
		else $error("rise enable not taken from write");

	a_fall_en_write: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
		sel && SFR_REQ_I.wr |=> mode_reg.cmp1_fall_irq_en == $past(SFR_REQ_I.wdata[4]))
		else $error("fall enable not taken from write");

	a_rise_sets_flag: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
		$rose(CMP1_OUT_I) |=> CMP1_RISE_FLAG_O)
		else $error("rising edge did not set flag");

	a_fall_sets_flag: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
		$fell(CMP1_OUT_I) |=> CMP1_FALL_FLAG_O)
		else $error("falling edge did not set flag");

	a_rise_flag_sticky: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
		CMP1_RISE_FLAG_O && !(FLAG_WR_I && !RISE_FLAG_WDATA_I) |=> CMP1_RISE_FLAG_O)
		else $error("rise flag dropped without clear");

	a_fall_flag_sticky: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
		CMP1_FALL_FLAG_O && !(FLAG_WR_I && !FALL_FLAG_WDATA_I) |=> CMP1_FALL_FLAG_O)
		else $error("fall flag dropped without clear");

	a_irq_has_cause: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
		CMP1_IRQ_O |-> (CMP1_RISE_FLAG_O && mode_reg.cmp1_rise_irq_en)
		|| (CMP1_FALL_FLAG_O && mode_reg.cmp1_fall_irq_en))
		else $error("irq high without an enabled flag");

	a_irq_rise: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
		CMP1_RISE_FLAG_O && mode_reg.cmp1_rise_irq_en |-> CMP1_IRQ_O)
		else $error("enabled rise flag gave no irq");

	a_irq_fall: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
		CMP1_FALL_FLAG_O && mode_reg.cmp1_fall_irq_en |-> CMP1_IRQ_O)
		else $error("enabled fall flag gave no irq");

	a_irq_masked: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
		!mode_reg.cmp1_rise_irq_en && !mode_reg.cmp1_fall_irq_en |-> !CMP1_IRQ_O)
		else $error("irq high with both enables clear");

	a_rise_set_wins: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
		rise_evt && FLAG_WR_I && !RISE_FLAG_WDATA_I |=> CMP1_RISE_FLAG_O)
		else $error("rise clear beat a same-cycle edge");

	a_fall_set_wins: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
		fall_evt && FLAG_WR_I && !FALL_FLAG_WDATA_I |=> CMP1_FALL_FLAG_O)
		else $error("fall clear beat a same-cycle edge");

	a_rise_clear: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
		FLAG_WR_I && !RISE_FLAG_WDATA_I && !rise_evt |=> !CMP1_RISE_FLAG_O)
		else $error("rise flag not cleared by zero write");

	a_fall_clear: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
		FLAG_WR_I && !FALL_FLAG_WDATA_I && !fall_evt |=> !CMP1_FALL_FLAG_O)
		else $error("fall flag not cleared by zero write");

	a_rise_no_self: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
		!CMP1_RISE_FLAG_O && !rise_evt |=> !CMP1_RISE_FLAG_O)
		else $error("rise flag set without an edge");

	a_fall_no_self: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
		!CMP1_FALL_FLAG_O && !fall_evt |=> !CMP1_FALL_FLAG_O)
		else $error("fall flag set without an edge");

	a_read_enables: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
		sel && SFR_REQ_I.rd |=> SFR_RDATA_O[5:4]
		== $past({mode_reg.cmp1_rise_irq_en, mode_reg.cmp1_fall_irq_en}))
		else $error("read data enables differ from register");

	a_read_mode_bits: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
		sel && SFR_REQ_I.rd |=> SFR_RDATA_O[1:0] == 2'($past(mode_reg.cmp1_resp_mode)))
		else $error("read data mode differs from register");

	a_rdata_idle: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
		!(sel && SFR_REQ_I.rd) |=> SFR_RDATA_O == 8'h00)
		else $error("read data nonzero without a read");

	a_unused_zero: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
		(mode_reg.unused_hi == 2'b00) && (mode_reg.unused_lo == 2'b00))
		else $error("unused mode bits hold a one");

	a_mode_holds: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
		!(sel && SFR_REQ_I.wr) |=> $stable(CMP1_RESP_MODE_O))
		else $error("response mode changed without a write");

	a_rise_en_hold: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
		!(sel && SFR_REQ_I.wr) |=> $stable(mode_reg.cmp1_rise_irq_en))
		else $error("rise enable changed without a write");

	a_fall_en_hold: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
		!(sel && SFR_REQ_I.wr) |=> $stable(mode_reg.cmp1_fall_irq_en))
		else $error("fall enable changed without a write");

endmodule

/* File: tb/comparator1_mode_irq_config_test.sv */
// Self-checking bench for the comparator1 mode register block
`timescale 1ns/10ps
`include "cmp1_mode_map.svh"

module comparator1_mode_irq_config_test
	import cmp1_mode_pkg::*;
;
	logic       mclk;
	logic       rst_n;
	sfr_req_t   req;
	logic       out;
	logic       fwr;
	logic       rfd;
	logic       ffd;
	logic [7:0] rdata;
	logic       rflag;
	logic       fflag;
	logic       irq;
	resp_mode_t mode;
	int         failures;
	int         tests_run;

	cmp1_mode_regs u_dut (
		.MCLK_I           (mclk),
		.RST_N_I          (rst_n),
		.SFR_REQ_I        (req),
		.SFR_RDATA_O      (rdata),
		.CMP1_OUT_I       (out),
		.FLAG_WR_I        (fwr),
		.RISE_FLAG_WDATA_I(rfd),
		.FALL_FLAG_WDATA_I(ffd),
		.CMP1_RISE_FLAG_O (rflag),
		.CMP1_FALL_FLAG_O (fflag),
		.CMP1_RESP_MODE_O (mode),
		.CMP1_IRQ_O       (irq)
	);

	// ==========================================================================
	// Helpers
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		req <= '{a, 1'b1, 1'b0, d};
		@(posedge mclk);
		req <= '0;
		#1;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge mclk);
		req <= '{a, 1'b0, 1'b1, 8'h00};
		@(posedge mclk);
		req <= '0;
		#1;
		chk(rdata, exp);
	endtask

	// Flag write; a one leaves the flag as it was
	task automatic clr(input logic r, input logic f);
		@(posedge mclk);
		fwr <= 1'b1;
		rfd <= r;
		ffd <= f;
		@(posedge mclk);
		fwr <= 1'b0;
		#1;
	endtask

	task automatic edge_to(input logic v, input logic [7:0] exp);
		@(posedge mclk);
		out <= v;
		tick(3);
		chk({5'h00, rflag, fflag, irq}, exp);
	endtask

	// ==========================================================================
	// Scenarios
	task automatic t_reset;
		rd(`CMP1_MODE_SEL_ADDR, `CMP1_MODE_SEL_RESET);
		chk({6'h00, mode}, 8'h02);
		chk({5'h00, rflag, fflag, irq}, 8'h00);
		$display("test reset done");
	endtask

	task automatic t_fields;
		wr(`CMP1_MODE_SEL_ADDR, 8'hFF);
		rd(`CMP1_MODE_SEL_ADDR, 8'h33);
		rd(8'h9B, 8'h00);
		for (int m = 0; m < 4; m++) begin
			wr(`CMP1_MODE_SEL_ADDR, 8'hCC | 8'(m));
			chk({6'h00, mode}, 8'(m));
			rd(`CMP1_MODE_SEL_ADDR, 8'(m));
		end
		$display("test fields done");
	endtask

	task automatic t_edges;
		wr(`CMP1_MODE_SEL_ADDR, 8'h20);
		edge_to(1'b1, 8'h05);
		edge_to(1'b0, 8'h07);
		clr(1'b1, 1'b0);
		chk({5'h00, rflag, fflag, irq}, 8'h05);
		clr(1'b0, 1'b1);
		chk({5'h00, rflag, fflag, irq}, 8'h00);
		wr(`CMP1_MODE_SEL_ADDR, 8'h10);
		edge_to(1'b1, 8'h04);
		edge_to(1'b0, 8'h07);
		clr(1'b0, 1'b0);
		chk({5'h00, rflag, fflag, irq}, 8'h00);
		$display("test edges done");
	endtask

	// Other address leaves the register; edges beat same-cycle clears
	task automatic t_corner;
		wr(8'h9D, 8'h00);
		rd(`CMP1_MODE_SEL_ADDR, 8'h10);
		@(posedge mclk);
		out <= 1'b1;
		fwr <= 1'b1;
		rfd <= 1'b0;
		ffd <= 1'b1;
		@(posedge mclk);
		out <= 1'b0;
		rfd <= 1'b1;
		ffd <= 1'b0;
		@(posedge mclk);
		fwr <= 1'b0;
		#1;
		chk({5'h00, rflag, fflag, irq}, 8'h07);
		$display("test corner done");
	endtask

	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		rst_n = 1'b0;
		req = '0;
		out = 1'b0;
		fwr = 1'b0;
		rfd = 1'b0;
		ffd = 1'b0;
		failures = 0;
		tests_run = 0;
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		t_reset;
		t_fields;
		t_edges;
		t_corner;
		finish_test;
	end
endmodule
